/* rtl/mips_phase_step.sv */
module mips_phase_step
	import mips_pkg::*;
(
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	input  wire logic [CNT_W-1:0]            period_i,  // Cycle length in clocks
	input  wire logic [2:0]                  count_i,   // Channels sharing the cycle
	output logic      [NUM_CH-1:0][CNT_W-1:0] offset_o  // Start offset per rank
);
	// Divide by a small count through fixed divisors
	function automatic logic [CNT_W+2:0] div_n(input logic [CNT_W+2:0] x,
	                                            input logic [2:0] n);
		unique case (n)
			3'h2:    div_n = (CNT_W+3)'(x / 2);
			3'h3:    div_n = (CNT_W+3)'(x / 3);
			3'h4:    div_n = (CNT_W+3)'(x / 4);
			3'h5:    div_n = (CNT_W+3)'(x / 5);
			3'h6:    div_n = (CNT_W+3)'(x / 6);
			default: div_n = x;
		endcase
	endfunction

	// Rank r starts r/N of a cycle after rank zero
	for (genvar r = 0; r < NUM_CH; r++) begin : g_rank
		logic [CNT_W+2:0] scaled; // Rank times period
		assign scaled = (CNT_W+3)'(r) * (CNT_W+3)'(period_i);
		always_ff @(posedge clock_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				offset_o[r] <= '0;
			end else begin
				offset_o[r] <= CNT_W'(div_n(scaled, count_i)); // see R11
			end
		end
	end
endmodule // mips_phase_step

/* rtl/mips_pkg.sv */
package mips_pkg;
	// Channel count and counter widths
	localparam int          NUM_CH         = 6;
	localparam int          CNT_W          = 12;
	localparam logic [2:0]  DEFAULT_PHASES = 3'h6;
	localparam logic [2:0]  NO_PHASES      = 3'h0;

	// Register map on the configuration port
	localparam logic [7:0]  ADDR_PHASE_DROP  = 8'hD2;
	localparam logic [7:0]  ADDR_SHED_CTRL   = 8'hD4;
	localparam logic [7:0]  ADDR_STATUS      = 8'hD6;
	localparam logic [1:0]  PHASE_DROP_RST   = 2'h0;
	localparam logic [1:0]  SHED_CTRL_RST    = 2'h0;
	localparam int          SHED_DIS_BIT     = 2;
	localparam int          MID_MODE_BIT     = 0;
	localparam int          DROP_MIN_BIT     = 0;
	localparam int          DROP_COUPLED_BIT = 1;

	// Timing: strap settle time and soft-start delay
	localparam int          CLK_MHZ          = 25;
	localparam int          STRAP_SETTLE_NS  = 200;
	localparam int          SOFT_DELAY_US    = 100;
	localparam int          STRAP_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int          DELAY_CYC = SOFT_DELAY_US * CLK_MHZ;
	localparam logic [11:0] STRAP_CYC_W      = 12'(STRAP_CYC);
	localparam logic [11:0] DELAY_CYC_W      = 12'(DELAY_CYC);

	// Feed-forward ramp: input code that stands for the 12 V reference
	localparam logic [7:0]  VIN_REF_CODE     = 8'hC0;

	// Phase drop modes
	typedef enum logic [1:0] {
		STANDARD_MIN_ONE_PHASE = 2'h0,
		STANDARD_MIN_TWO_PHASE = 2'h1,
		COUPLED_MIN_ONE_PHASE  = 2'h2,
		COUPLED_MIN_TWO_PHASE  = 2'h3
	} mips_drop_mode_t;

	// One tri-level output pin: drive enable, logic level, mid level
	typedef struct packed {
		logic oe;
		logic level;
		logic mid;
	} mips_pin_t;
endpackage : mips_pkg

/* rtl/mips_ramp_scale.sv */
module mips_ramp_scale
	import mips_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] vin_code_i,   // Input voltage sense code
	input  wire logic [7:0] adj_code_i,   // Ramp adjust setting
	output logic      [7:0] ramp_amp_o    // Scaled ramp up-slope amplitude
);
	logic [15:0] prod;                    // Input times adjust
	logic [15:0] quot;                    // Product over reference code

	// Constant divisor keeps this a fixed reciprocal, not a divider loop
	always_comb begin
		prod = 16'(vin_code_i) * 16'(adj_code_i);
		quot = prod / 16'(VIN_REF_CODE);
	end

	// Saturate so a high input cannot wrap the amplitude to small values
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ramp_amp_o <= 8'h00;
		end else if (quot > 16'h00FF) begin
			ramp_amp_o <= 8'hFF;
		end else begin
			ramp_amp_o <= quot[7:0]; // see R06
		end
	end
endmodule // mips_ramp_scale

/* rtl/mips_sequencer.sv */
// Summary of operation
// R01 - Space active channels symmetrically across cycle
// R02 - Each pulse ends 1/N after previous
// R03 - Leading and trailing edges move independently
// R04 - Large load step fires all phases together
// R05 - Pulses spread evenly over active phases
// R06 - Ramp amplitude equals input times adjust/12V
// R07 - Steady state is trailing-edge modulation; code moves the leading edge with duty, pulse end fixed at local wrap
// R08 - Cycle is pulse end to pulse end
// R09 - No strap means six active channels
// R10 - Output N+1 tied high selects N phases
// R11 - Fire channels 1..N, spaced 1/N cycle
// R12 - Pin two high: one phase; one: off
// R13 - Shedding begins on next switching cycle
// R14 - Assist restores all configured phases immediately
// R15 - Coupled pair runs 180 degrees apart
// R16 - Dropped coupled phase low while phase one high
// R17 - Low power keeps channel one plus partner
// R18 - Two-bit drop field picks inductor, minimum count
// R19 - Idle outputs mid level in delay, shed, fault
// R20 - Mid level selectable for 3.3V or 5V
// R21 - Operational needs POR, both enables, valid VID
// R22 - Drop field and pin select coupling behaviour
// R23 - Grounded pin or control bit disables shedding
// R24 - Strap sampled once before soft start, held
module mips_sequencer
	import mips_pkg::*;
(
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// Supply and enable status
	input  wire logic                 por_ok_i,               // Supply above power-on reset
	input  wire logic                 thermal_enable_input_i, // Thermal enable pin high
	input  wire logic                 power_enable_input_i,   // Power enable pin high
	input  wire logic                 vid_valid_i,            // Voltage code valid
	input  wire logic                 fault_i,                // Overcurrent or overvoltage
	// Modulator controls
	input  wire logic [CNT_W-1:0]     period_i,       // Clocks per switching cycle
	input  wire logic [CNT_W-1:0]     duty_i,         // Steady-state on time
	input  wire logic [CNT_W-1:0]     lead_adv_i,     // Leading edge advance
	input  wire logic [CNT_W-1:0]     trail_ext_i,    // Trailing edge extension
	input  wire logic                 assist_i,       // Large load step detected
	input  wire logic                 light_load_i,   // Light load detected
	input  wire logic                 shed_pin_gnd_i, // Shedding threshold pin grounded
	input  wire logic [7:0]           input_voltage_sense_i,
	input  wire logic [7:0]           ramp_adjust_setting_i,
	// Register port
	input  wire logic                 reg_wr_i,       // Write strobe
	input  wire logic                 reg_rd_i,       // Read strobe
	input  wire logic [7:0]           reg_addr_i,     // Register offset
	input  wire logic [7:0]           reg_wdata_i,    // Write data
	output logic      [7:0]           reg_rdata_o,    // Read data, one cycle later
	// Output pins, each sensed for straps before start
	input  wire logic [NUM_CH-1:0]    pwm_in_i,       // Sensed pin levels
	output mips_pin_t [NUM_CH-1:0]    pwm_o,          // Pin drive
	output logic                      mid_sel_o,      // Mid level: 1 = 5 V, 0 = 3.3 V
	output logic      [7:0]           ramp_amp_o,     // Feed-forward ramp amplitude
	output logic      [2:0]           phase_count_o   // Configured phase count
);
	typedef enum logic [1:0] {ST_SENSE, ST_DELAY, ST_RUN, ST_OFF} mips_state_t;

	mips_state_t                  state_ff;        // Sequencer state
	logic [11:0]                  tmr_ff;          // Settle and delay timer
	logic [2:0]                   nphase_ff;       // Strapped phase count
	logic [1:0]                   drop_cfg_ff;     // Phase drop field
	logic [1:0]                   shed_ctrl_ff;    // Bit 1: shed disable, bit 0: mid mode
	logic [CNT_W-1:0]             cnt_ff;          // Switching cycle counter
	logic                         shed_ff;         // Shedding in force
	logic [2:0]                   nxt_nphase;      // Count decoded from straps
	logic                         operational;     // All enables present
	logic                         wrap;            // Last clock of the cycle
	logic                         shed_ok;         // Shedding permitted
	logic                         coupled;         // Two-phase coupled mode
	logic                         min_two;         // Two-phase minimum
	logic [2:0]                   partner;         // Second channel index when shed
	logic [2:0]                   active_cnt;      // Channels sharing the cycle
	logic [NUM_CH-1:0][CNT_W-1:0] offset;          // Offset per rank
	logic [CNT_W:0]               duty_eff;        // Duty plus leading advance
	mips_pin_t [NUM_CH-1:0]       nxt_pin;         // Next pin drive

	// Operational only with supply, both enables and a valid voltage code
	assign operational = por_ok_i && thermal_enable_input_i
	                     && power_enable_input_i && vid_valid_i; // see R21

	// Lowest strapped pin sets the count; no strap means six phases
	always_comb begin
		nxt_nphase = DEFAULT_PHASES; // see R09
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pwm_in_i[i]) begin
				nxt_nphase = 3'(i); // see R10 R12
			end
		end
	end

	// Sequencer: sense straps, soft-start delay, run; restart on disable
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_SENSE;
		end else if (!operational) begin
			state_ff <= ST_SENSE;
		end else begin
			unique case (state_ff)
				ST_SENSE: if (tmr_ff == STRAP_CYC_W) begin
					state_ff <= (nxt_nphase == NO_PHASES) ? ST_OFF : ST_DELAY; // see R12
				end
				ST_DELAY: if (tmr_ff == DELAY_CYC_W) begin
					state_ff <= ST_RUN;
				end
				ST_RUN:   state_ff <= ST_RUN;
				ST_OFF:   state_ff <= ST_OFF;
			endcase
		end
	end

	// Timer restarts at the end of sensing and on disable; held at zero in run and off
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmr_ff <= 12'h000;
		end else if (!operational
		             || (state_ff == ST_SENSE && tmr_ff == STRAP_CYC_W)
		             || state_ff == ST_RUN || state_ff == ST_OFF) begin
			tmr_ff <= 12'h000;
		end else begin
			tmr_ff <= tmr_ff + 12'h001;
		end
	end

	// Strap caught once, at the end of sensing, held until restart
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nphase_ff <= DEFAULT_PHASES;
		end else if (state_ff == ST_SENSE && tmr_ff == STRAP_CYC_W) begin
			nphase_ff <= nxt_nphase; // see R24
		end
	end

	// Register writes; unmapped offsets are ignored
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drop_cfg_ff  <= PHASE_DROP_RST;
			shed_ctrl_ff <= SHED_CTRL_RST;
		end else if (reg_wr_i && reg_addr_i == ADDR_PHASE_DROP) begin
			drop_cfg_ff <= reg_wdata_i[1:0]; // see R18
		end else if (reg_wr_i && reg_addr_i == ADDR_SHED_CTRL) begin
			shed_ctrl_ff <= {reg_wdata_i[SHED_DIS_BIT], reg_wdata_i[MID_MODE_BIT]};
		end
	end

	// Read data; status shows shedding and the strapped count
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_PHASE_DROP: reg_rdata_o <= {6'h00, drop_cfg_ff};
				ADDR_SHED_CTRL:  reg_rdata_o <= {5'h00, shed_ctrl_ff[1], 1'b0,
				                                shed_ctrl_ff[0]};
				ADDR_STATUS:     reg_rdata_o <= {shed_ff, state_ff, 2'h0, nphase_ff};
				default:         reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// Mode decode from the drop field and the threshold pin
	assign coupled = drop_cfg_ff[DROP_COUPLED_BIT]; // see R22
	assign min_two = drop_cfg_ff[DROP_MIN_BIT];
	assign shed_ok = !shed_pin_gnd_i && !shed_ctrl_ff[1] && !assist_i; // see R23

	// Coupled pair is channels one and two; otherwise partner follows count
	assign partner = (coupled || nphase_ff < 3'h4) ? 3'h1 : 3'h2; // see R17

	// Shedding only begins at the cycle boundary; assist, a grounded pin or the disable bit clear it at once
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shed_ff <= 1'b0;
		end else if (state_ff != ST_RUN || !shed_ok) begin
			shed_ff <= 1'b0; // see R14
		end else if (wrap) begin
			shed_ff <= light_load_i && (nphase_ff > (min_two ? 3'h2 : 3'h1)); // see R13
		end
	end

	// Count of channels sharing the cycle sets the spacing
	assign active_cnt = shed_ff ? (min_two ? 3'h2 : 3'h1) : nphase_ff; // see R05

	mips_phase_step u_step (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.period_i (period_i),
		.count_i  (active_cnt),
		.offset_o (offset)
	);

	mips_ramp_scale u_ramp (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.vin_code_i (input_voltage_sense_i),
		.adj_code_i (ramp_adjust_setting_i),
		.ramp_amp_o (ramp_amp_o)
	);

	// Cycle counter; the cycle runs pulse end to pulse end
	assign wrap = (cnt_ff >= period_i - CNT_W'(1)); // see R08
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else if (state_ff != ST_RUN || wrap) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

	// Leading advance widens the pulse at its start only
	assign duty_eff = (CNT_W+1)'(duty_i) + (CNT_W+1)'(lead_adv_i); // see R03

	// Per-channel pulse placement and tri-level drive
	for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
		logic           active; // Channel fires this cycle
		logic [2:0]     rank;   // Position in the firing order
		logic [CNT_W:0] lc;     // Local count since this channel's pulse end
		logic           pulse;  // Channel high

		always_comb begin
			active = 1'b0;
			rank   = 3'h0;
			if (shed_ff) begin
				if (k == 0) begin
					active = 1'b1;
				end else if (min_two && 3'(k) == partner) begin
					active = 1'b1;
					rank   = 3'h1; // see R15
				end
			end else begin
				active = (3'(k) < nphase_ff); // see R11
				rank   = 3'(k);
			end
		end

		// Local count is the cycle count shifted back by the rank offset
		always_comb begin
			if (cnt_ff >= offset[rank]) begin
				lc = (CNT_W+1)'(cnt_ff - offset[rank]);
			end else begin
				lc = (CNT_W+1)'(cnt_ff) + (CNT_W+1)'(period_i) - (CNT_W+1)'(offset[rank]);
			end
		end

		// Pulse ends at the local wrap; extension holds it past the end
		assign pulse = (lc + duty_eff >= (CNT_W+1)'(period_i))
		               || (lc < (CNT_W+1)'(trail_ext_i)); // see R01 R02 R07

		always_comb begin
			nxt_pin[k] = '{oe: 1'b0, level: 1'b0, mid: 1'b0};
			// Only configured pins: the strapped pin above them is tied to supply
			if ((state_ff == ST_DELAY || (state_ff == ST_RUN && fault_i))
			    && 3'(k) < nphase_ff) begin
				nxt_pin[k] = '{oe: 1'b1, level: 1'b0, mid: 1'b1}; // see R19
			end else if (state_ff == ST_RUN && active) begin
				nxt_pin[k] = '{oe: 1'b1, level: pulse || assist_i, mid: 1'b0}; // see R04
			end else if (state_ff == ST_RUN && shed_ff && coupled && k == 1) begin
				// Low side circulates current while phase one is high
				nxt_pin[k] = '{oe: 1'b1, level: 1'b0, mid: !nxt_pin[0].level}; // see R16
			end else if (state_ff == ST_RUN && 3'(k) < nphase_ff) begin
				nxt_pin[k] = '{oe: 1'b1, level: 1'b0, mid: 1'b1}; // see R19
			end
		end
	end

	// Registered pin drive and status outputs
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_o         <= '0;
			mid_sel_o     <= 1'b0;
			phase_count_o <= DEFAULT_PHASES;
		end else begin
			pwm_o         <= nxt_pin;
			mid_sel_o     <= shed_ctrl_ff[0]; // see R20
			phase_count_o <= nphase_ff;
		end
	end

	// Assertions
	property p_strap_hold;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == ST_RUN && $past(state_ff) == ST_RUN) |-> $stable(nphase_ff);
	endproperty
	a_strap_hold: assert property (p_strap_hold) // see R24
		else $error("phase count changed while running");

	property p_default_six;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == ST_SENSE && tmr_ff == STRAP_CYC_W && pwm_in_i == '0 && operational)
		|=> nphase_ff == DEFAULT_PHASES;
	endproperty
	a_default_six: assert property (p_default_six) // see R09
		else $error("no strap did not give six phases");

	property p_off_quiet;
		@(posedge clock_i) disable iff (!rst_n_i)
		state_ff == ST_OFF |=> pwm_o == '0;
	endproperty
	a_off_quiet: assert property (p_off_quiet) // see R12
		else $error("outputs driven with regulator off");

	property p_shed_boundary;
		@(posedge clock_i) disable iff (!rst_n_i)
		$rose(shed_ff) |-> $past(wrap);
	endproperty
	a_shed_boundary: assert property (p_shed_boundary) // see R13
		else $error("shedding began away from the cycle boundary");

	property p_assist_restore;
		@(posedge clock_i) disable iff (!rst_n_i)
		assist_i |=> !shed_ff;
	endproperty
	a_assist_restore: assert property (p_assist_restore) // see R14
		else $error("assist did not restore all phases");

	sequence s_assist_run;
		state_ff == ST_RUN && !fault_i && assist_i;
	endsequence
	property p_assist_all;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_assist_run ##0 !shed_ff |=> pwm_o[0].level && pwm_o[nphase_ff - 3'h1].level;
	endproperty
	a_assist_all: assert property (p_assist_all) // see R04
		else $error("assist did not fire all phases together");

	sequence s_delay_two;
		state_ff == ST_DELAY [*2];
	endsequence
	property p_delay_mid;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_delay_two |-> pwm_o[0].mid && pwm_o[0].oe && !pwm_o[0].level;
	endproperty
	a_delay_mid: assert property (p_delay_mid) // see R19
		else $error("outputs not at mid level during soft-start delay");

	property p_enable_drop;
		@(posedge clock_i) disable iff (!rst_n_i)
		!operational |=> state_ff == ST_SENSE ##1 pwm_o == '0;
	endproperty
	a_enable_drop: assert property (p_enable_drop) // see R21
		else $error("lost enable did not stop the regulator");

	property p_coupled_low;
		@(posedge clock_i) disable iff (!rst_n_i)
		(state_ff == ST_RUN && !fault_i && shed_ff && coupled && !min_two
		 && nxt_pin[0].level) |=> pwm_o[1].oe && !pwm_o[1].mid && !pwm_o[1].level;
	endproperty
	a_coupled_low: assert property (p_coupled_low) // see R16
		else $error("dropped coupled phase not low while phase one high");
endmodule // mips_sequencer

/* testbench/mips_driver_model.sv */
module mips_driver_model
	import mips_pkg::*;
(
	input  wire mips_pin_t [NUM_CH-1:0] pwm_i,   // Controller pin drive
	input  wire logic      [2:0]        strap_i, // Strapped count, 6 = none
	output logic           [NUM_CH-1:0] sense_o, // Level seen on each pin
	output logic           [NUM_CH-1:0] on_o     // High side on per phase
);
	// Pin N+1 is tied to supply; a released pin otherwise sits at the
	// driver's divider level, which never reads high
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			// Tie wins only while released
			sense_o[i] = pwm_i[i].oe ? (pwm_i[i].level & ~pwm_i[i].mid)
			                         : (i == int'(strap_i));
			// Mid level means both switches off
			on_o[i]    = pwm_i[i].oe & ~pwm_i[i].mid & pwm_i[i].level;
		end
	end
endmodule // mips_driver_model

/* testbench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mips_pkg::*;
	localparam int P = 12;              // Switching period in clocks
	logic                   clock_i;    // 25 MHz clock
	logic                   rst_n_i;    // Reset, active low
	logic [3:0]             en;         // POR, two enables, code valid
	logic                   fault;      // Fault level
	logic                   assist;     // Load step level
	logic                   light;      // Light load level
	logic                   gnd;        // Threshold pin grounded
	logic                   wr;         // Register write strobe
	logic                   rd;         // Register read strobe
	logic [7:0]             addr;       // Register offset
	logic [7:0]             wdata;      // Register write data
	logic [7:0]             vin;        // Input voltage code
	logic [7:0]             adj;        // Ramp adjust code
	logic [7:0]             rdata;      // Register read data
	logic [7:0]             got;        // Last value read
	logic [CNT_W-1:0]       per;        // Period
	logic [CNT_W-1:0]       duty;       // On time
	logic [CNT_W-1:0]       lead;       // Leading edge advance
	logic [CNT_W-1:0]       trail;      // Trailing edge extension
	logic [NUM_CH-1:0]      sense;      // Sensed pin levels
	logic [NUM_CH-1:0]      on;         // Driver high side state
	mips_pin_t [NUM_CH-1:0] pwm;        // Pin drive
	logic                   mid_sel;    // Mid level choice
	logic [7:0]             ramp;       // Ramp amplitude
	logic [2:0]             pcount;     // Configured count
	logic [2:0]             strap;      // Board strap for the model
	int                     n_mismatch; // Mismatches seen
	int                     num_checks; // Comparisons made
	int                     seed;       // Random seed
	int                     fall[NUM_CH];

	mips_sequencer DUT (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .por_ok_i(en[0]),
		.thermal_enable_input_i(en[1]), .power_enable_input_i(en[2]),
		.vid_valid_i(en[3]), .fault_i(fault), .period_i(per), .duty_i(duty),
		.lead_adv_i(lead), .trail_ext_i(trail), .assist_i(assist),
		.light_load_i(light), .shed_pin_gnd_i(gnd),
		.input_voltage_sense_i(vin), .ramp_adjust_setting_i(adj),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .pwm_in_i(sense), .pwm_o(pwm), .mid_sel_o(mid_sel),
		.ramp_amp_o(ramp), .phase_count_o(pcount));

	mips_driver_model u_drv (.pwm_i(pwm), .strap_i(strap), .sense_o(sense), .on_o(on));

	// Free running clock
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	// Compare and report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	// Extra wait is harmless, read data stands until the next read
	task automatic rreg(input logic [7:0] a);
		@(posedge clock_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_i);
		rd <= 1'b0;
		repeat (2) @(negedge clock_i);
		got = rdata;
	endtask

	// Reset with a strap; enables stay high so the strap is taken
	task automatic boot(input logic [2:0] s);
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		strap <= s;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (20) @(posedge clock_i);
	endtask

	// Soft-start pins, then pulse ends and widths over two periods
	task automatic interleave(input int m);
		int f0;
		int w;
		logic [NUM_CH-1:0] pon;
		repeat (40) @(negedge clock_i);
		for (int c = 0; c < NUM_CH; c++)
			chk({pwm[c].oe, pwm[c].mid}, (c < m) ? 2'h3 : 2'h0); // Delay
		repeat (2600) @(negedge clock_i);
		for (int k = 0; k < 2; k++) begin
			@(posedge clock_i);
			lead <= 12'(2 * k);
			trail <= 12'(k);
			repeat (2 * P) @(negedge clock_i);
			w = 0;
			f0 = -1;
			pon = on;
			for (int t = 0; t < 2 * P; t++) begin
				@(negedge clock_i);
				w += int'(on[0]);
				for (int c = 0; c < m; c++)
					if (pon[c] & ~on[c]) begin
						if (c == 0 && f0 < 0)
							f0 = t;
						fall[c] = t;
					end
				pon = on;
			end
			chk(w, 2 * (3 + 3 * k)); // Edge moves
			chk(fall[0] - f0, P); // End to end
			for (int c = 1; c < m; c++)
				chk((fall[c] - fall[0] + 2 * P) % P, c * P / m); // Spacing
		end
	endtask

	// Hang guard, over six times the expected run
	initial begin
		#(40 * 40000);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		int e;
		seed = 32'h1F01;
		rst_n_i = 1'b0;
		en = 4'hF;
		{fault, assist, light, gnd, wr, rd} = 6'h00;
		{addr, wdata, vin, adj} = 32'h0000_0000;
		per = 12'(P);
		duty = 12'h003;
		lead = 12'h000;
		trail = 12'h000;
		strap = 3'h6;
		n_mismatch = 0;
		num_checks = 0;
		boot(3'h6);
		chk(pcount, DEFAULT_PHASES); // No strap
		rreg(ADDR_PHASE_DROP);
		chk(got, 8'h00); // Reset value
		for (int i = 0; i < 4; i++) begin
			wreg(ADDR_PHASE_DROP, (8'($random(seed)) & 8'hFC) | 8'(i));
			rreg(ADDR_PHASE_DROP);
			chk(got, 8'(i)); // Drop modes
		end
		wreg(8'h55, 8'hFF);
		rreg(8'h55);
		chk(got, 8'h00); // Unmapped offset
		repeat (4) begin
			@(posedge clock_i);
			vin <= 8'($random(seed));
			adj <= 8'($random(seed));
			repeat (4) @(negedge clock_i);
			e = int'(vin) * int'(adj) / int'(VIN_REF_CODE);
			chk(ramp, (e > 255) ? 255 : e); // Feed-forward
		end
		for (int s = 0; s < 6; s++) begin
			boot(3'(s));
			chk(pcount, s); // Strap count
		end
		boot(3'h1);
		chk(pwm, 32'h0000_0005); // Only channel one driven
		boot(3'h0);
		chk(pwm, '0); // Strap on pin one keeps all off
		boot(3'h3);
		interleave(3);
		wreg(ADDR_SHED_CTRL, 8'h04);
		@(posedge clock_i);
		light <= 1'b1;
		repeat (3 * P) @(negedge clock_i);
		chk(pwm[1].mid, 1'b0); // Shedding disabled
		@(posedge clock_i);
		gnd <= 1'b1;
		wreg(ADDR_SHED_CTRL, 8'h00);
		repeat (3 * P) @(negedge clock_i);
		chk(pwm[1].mid, 1'b0); // Grounded threshold pin
		@(posedge clock_i);
		gnd <= 1'b0;
		wreg(ADDR_SHED_CTRL, 8'h01);
		rreg(ADDR_SHED_CTRL);
		chk(got, 8'h01); // Mid mode read back
		repeat (3 * P) @(negedge clock_i);
		chk(mid_sel, 1'b1); // Mid choice
		chk({pwm[1].oe, pwm[1].mid, pwm[2].oe, pwm[2].mid}, 4'hF); // Shed
		rreg(ADDR_STATUS);
		chk(got[7], 1'b1); // Shedding flag
		chk(got[6:0], 7'h43); // Run state, three phases
		wreg(ADDR_PHASE_DROP, 8'h01);
		repeat (3 * P) @(negedge clock_i);
		chk({pwm[1].oe, pwm[1].mid, pwm[2].oe, pwm[2].mid}, 4'hB); // Two kept
		@(posedge clock_i);
		assist <= 1'b1;
		repeat (3) @(negedge clock_i);
		chk(on[2:0], 3'h7); // All on together
		@(posedge clock_i);
		assist <= 1'b0;
		light <= 1'b0;
		fault <= 1'b1;
		repeat (3) @(negedge clock_i);
		for (int c = 0; c < 3; c++)
			chk({pwm[c].oe, pwm[c].mid}, 2'h3); // Fault level
		@(posedge clock_i);
		fault <= 1'b0;
		en[2] <= 1'b0;
		repeat (3) @(negedge clock_i);
		chk(pwm, '0); // Not operational
		@(posedge clock_i);
		en[2] <= 1'b1;
		boot(3'h2);
		wreg(ADDR_PHASE_DROP, 8'h02);
		interleave(2);
		@(posedge clock_i);
		light <= 1'b1;
		repeat (3 * P) @(negedge clock_i);
		repeat (2 * P) begin
			@(negedge clock_i);
			if (on[0])
				chk({pwm[1].oe, pwm[1].mid, pwm[1].level}, 3'h4); // Low side on
			else
				chk({pwm[1].oe, pwm[1].mid}, 2'h3); // Coupled idle
		end
		end_of_test();
	end
endmodule // testbench
